// *** rtl/pefi_flags.sv ***
`timescale 1ns/100ps
`default_nettype none

module pefi_flags (
	input  wire logic                   mclk_in,   // Clock, 250 MHz.
	input  wire logic                   rst_n_in,  // Sync reset, low.
	input  wire pefi_pkg::pefi_cond_type cond_in,  // Monitored conditions.
	input  wire pefi_pkg::pefi_req_type  req_in,   // Register access.
	output logic [7:0]                  rdata_out, // Read data, registered.
	output logic                        irq_n_out  // Interrupt, low.
);

	pefi_pkg::pefi_state_type s_q;
	pefi_pkg::pefi_state_type s_d;
	logic [5:0]               hit_sys;
	logic [5:0]               hit_sw;

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	// Conditions are watched regardless of mask state.
	always_comb begin
		hit_sys = '0;
		hit_sw = '0;
		hit_sys[pefi_pkg::BIT_PROG_LOW] = cond_in.prog_supply_low;
		hit_sys[pefi_pkg::BIT_SUPPLY_CHG] = s_q.edge_ok &&
			(cond_in.supply_detect_input != s_q.sd_prev);
		hit_sys[pefi_pkg::BIT_BUTTON_CHG] = s_q.edge_ok &&
			(cond_in.button_input != s_q.pb_prev);
		hit_sys[pefi_pkg::BIT_THERMAL] = cond_in.thermal_warning;
		hit_sys[pefi_pkg::BIT_MEAS_DONE] = cond_in.backup_measure_done;
		hit_sys[pefi_pkg::BIT_NVM_DONE] = cond_in.nvm_program_done;
		hit_sw[5] = cond_in.switch_fault[2];
		hit_sw[4] = cond_in.switch_fault[1];
		hit_sw[3] = cond_in.switch_fault[0];
		hit_sw[2:0] = cond_in.switch_limit;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A read clears an event register, but a same-cycle event still sets it.
	always_comb begin
		s_d = s_q;
		s_d.sd_prev = cond_in.supply_detect_input;
		s_d.pb_prev = cond_in.button_input;
		s_d.edge_ok = 1'b1;
		if (req_in.rd) begin
			unique case (req_in.addr)
				pefi_pkg::ADDR_PART_IDENTITY: begin
					s_d.rdata = {pefi_pkg::PART_ID_VALUE,
						pefi_pkg::REVISION_FIELD_VALUE};
				end
				pefi_pkg::ADDR_EVENT_SYSTEM: begin
					s_d.rdata = {2'h0, s_q.ev_sys};
					s_d.ev_sys = '0;
				end
				pefi_pkg::ADDR_EVENT_SWITCHES: begin
					s_d.rdata = {2'h0, s_q.ev_sw};
					s_d.ev_sw = '0;
				end
				pefi_pkg::ADDR_MASK_SYSTEM: s_d.rdata = {2'h0, s_q.mask_sys};
				pefi_pkg::ADDR_MASK_SWITCHES: s_d.rdata = {2'h0, s_q.mask_sw};
				default: s_d.rdata = 8'h00;
			endcase
		end
		if (req_in.wr) begin
			if (req_in.addr == pefi_pkg::ADDR_MASK_SYSTEM) begin
				s_d.mask_sys = req_in.wdata[5:0];
			end
			if (req_in.addr == pefi_pkg::ADDR_MASK_SWITCHES) begin
				s_d.mask_sw = req_in.wdata[5:0];
			end
		end
		s_d.ev_sys = s_d.ev_sys | hit_sys;
		s_d.ev_sw = s_d.ev_sw | hit_sw;
		s_d.irq_n = ~(|(s_d.ev_sys & ~s_d.mask_sys) |
			|(s_d.ev_sw & ~s_d.mask_sw));
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset state: flags and masks cleared, interrupt released.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s_q.ev_sys <= pefi_pkg::EVENT_RESET;
			s_q.ev_sw <= pefi_pkg::EVENT_RESET;
			s_q.mask_sys <= pefi_pkg::MASK_RESET;
			s_q.mask_sw <= pefi_pkg::MASK_RESET;
			s_q.sd_prev <= 1'b0;
			s_q.pb_prev <= 1'b0;
			s_q.edge_ok <= 1'b0;
			s_q.rdata <= 8'h00;
			s_q.irq_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops.
	assign rdata_out = s_q.rdata;
	assign irq_n_out = s_q.irq_n;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	chk_ident_read: assert property (req_in.rd && req_in.addr == 8'h00 |=>
		rdata_out == {pefi_pkg::PART_ID_VALUE,
		pefi_pkg::REVISION_FIELD_VALUE})
		else $error("identity read wrong");
	chk_sys_reserved: assert property (req_in.rd && req_in.addr == 8'h01
		|=> rdata_out[7:6] == 2'h0)
		else $error("system reserved bits set");
	chk_prog_low_set: assert property (cond_in.prog_supply_low
		|=> s_q.ev_sys[5])
		else $error("prog low not flagged");
	chk_supply_edge: assert property (s_q.edge_ok &&
		cond_in.supply_detect_input != $past(cond_in.supply_detect_input)
		|=> s_q.ev_sys[4])
		else $error("supply change missed");
	chk_button_edge: assert property (s_q.edge_ok &&
		cond_in.button_input != $past(cond_in.button_input)
		|=> s_q.ev_sys[3])
		else $error("button change missed");
	chk_thermal_set: assert property (cond_in.thermal_warning
		|=> s_q.ev_sys[2])
		else $error("thermal not flagged");
	chk_meas_set: assert property (cond_in.backup_measure_done
		|=> s_q.ev_sys[1])
		else $error("measure done not flagged");
	chk_nvm_set: assert property (cond_in.nvm_program_done
		|=> s_q.ev_sys[0])
		else $error("nvm done not flagged");
	chk_sw_reserved: assert property (req_in.rd && req_in.addr == 8'h02
		|=> rdata_out[7:6] == 2'h0 && rdata_out[5:0] == $past(s_q.ev_sw))
		else $error("switch read wrong");
	chk_fault_map: assert property (cond_in.switch_fault[2] &&
		cond_in.switch_fault[0] |=> s_q.ev_sw[5] && s_q.ev_sw[3])
		else $error("fault 3 or 1 missed");
	chk_fault2_map: assert property (cond_in.switch_fault[1]
		|=> s_q.ev_sw[4])
		else $error("fault 2 missed");
	chk_limit_map: assert property (cond_in.switch_limit != 3'h0 |=>
		(s_q.ev_sw[2:0] & $past(cond_in.switch_limit)) ==
		$past(cond_in.switch_limit))
		else $error("limit missed");
	chk_irq_unmask: assert property (irq_n_out == ~(|(s_q.ev_sys &
		~s_q.mask_sys) | |(s_q.ev_sw & ~s_q.mask_sw)))
		else $error("interrupt level wrong");
	chk_mask_monitor: assert property (s_q.mask_sys[2] &&
		cond_in.thermal_warning |=> s_q.ev_sys[2])
		else $error("masked event not latched");
	chk_read_clear: assert property (req_in.rd && req_in.addr == 8'h01 &&
		hit_sys == 6'h00 |=> s_q.ev_sys == 6'h00)
		else $error("read did not clear");

	cov_irq_fire: cover property (irq_n_out ##1 !irq_n_out);
	cov_read_clear: cover property (req_in.rd && req_in.addr == 8'h01 &&
		s_q.ev_sys != 6'h00);
	cov_masked_evt: cover property (s_q.ev_sw != 6'h00 && irq_n_out);

endmodule // pefi_flags

`default_nettype wire

// *** rtl/pefi_pkg.sv ***
package pefi_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PART_IDENTITY = 8'h00;
	localparam logic [7:0] ADDR_EVENT_SYSTEM = 8'h01;
	localparam logic [7:0] ADDR_EVENT_SWITCHES = 8'h02;
	localparam logic [7:0] ADDR_MASK_SYSTEM = 8'h03;
	localparam logic [7:0] ADDR_MASK_SWITCHES = 8'h04;

	// ----------------------------------------------------------------
	// Identity fields, values arbitrary
	// ----------------------------------------------------------------
	localparam logic [4:0] PART_ID_VALUE = 5'h0A; // Arbitrary value.
	localparam logic [2:0] REVISION_FIELD_VALUE = 3'h1; // Arbitrary value.

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int FLAG_WIDTH = 6;
	localparam int BIT_PROG_LOW = 5;
	localparam int BIT_SUPPLY_CHG = 4;
	localparam int BIT_BUTTON_CHG = 3;
	localparam int BIT_THERMAL = 2;
	localparam int BIT_MEAS_DONE = 1;
	localparam int BIT_NVM_DONE = 0;
	localparam logic [5:0] EVENT_RESET = 6'h00;
	localparam logic [5:0] MASK_RESET = 6'h00;

	// Condition inputs from the analog side.
	typedef struct packed {
		logic prog_supply_low;
		logic supply_detect_input;
		logic button_input;
		logic thermal_warning;
		logic backup_measure_done;
		logic nvm_program_done;
		logic [2:0] switch_fault;   // Index 2..0 = switch 3..1.
		logic [2:0] switch_limit;   // Index 2..0 = switch 3..1.
	} pefi_cond_type;

	// Register access request.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pefi_req_type;

	// All state of the block.
	typedef struct packed {
		logic [5:0] ev_sys;
		logic [5:0] ev_sw;
		logic [5:0] mask_sys;
		logic [5:0] mask_sw;
		logic       sd_prev;
		logic       pb_prev;
		logic       edge_ok;
		logic [7:0] rdata;
		logic       irq_n;
	} pefi_state_type;

endpackage

// *** test/pefi_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Host side of the register access
// ----------------------------------------------------------------
module pefi_host_model (
	input  wire pefi_pkg::pefi_req_type cmd_in,  // Bench request.
	output var  pefi_pkg::pefi_req_type req_out  // Request to device.
);
	// Idle address and data lines flip, so stale values never look valid.
	always_comb begin
		req_out = cmd_in;
		if (!(cmd_in.rd || cmd_in.wr)) begin
			req_out.addr  = ~cmd_in.addr;
			req_out.wdata = ~cmd_in.wdata;
		end
	end
endmodule // pefi_host_model

`default_nettype wire

// *** test/pmic_event_flags_and_id_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module pmic_event_flags_and_id_tb_top;
	logic                    mclk_in;
	logic                    rst_n_in;
	pefi_pkg::pefi_cond_type cond;
	pefi_pkg::pefi_req_type  cmd;
	pefi_pkg::pefi_req_type  req;
	logic [7:0]              rdata;
	logic                    irq_n;
	int                      num_errors;
	int                      cmp_count;
	localparam logic [7:0] ID = {pefi_pkg::PART_ID_VALUE,
		pefi_pkg::REVISION_FIELD_VALUE};
	// Rows are address, one condition pulse and the expected read data.
	localparam logic [27:0] ROWS [13] = '{{8'h00, 12'h000, ID},
		28'h0180020, 28'h0140010, 28'h0120008, 28'h0110004,
		28'h0108002, 28'h0104001, 28'h0202020, 28'h0201010,
		28'h0200808, 28'h0200404, 28'h0200202, 28'h0200101};

	pefi_flags u_pefi_flags (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.cond_in(cond), .req_in(req), .rdata_out(rdata),
		.irq_n_out(irq_n));
	pefi_host_model u_pefi_host_model (.cmd_in(cmd), .req_out(req));

	// ----------------------------------------------------------------
	// Clock, helpers and verdict
	// ----------------------------------------------------------------
	// The clock toggles every 2 ns for 250 MHz.
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end

	task automatic step;
		@(posedge mclk_in);
		#1;
	endtask

	task automatic check(input string name, input logic [7:0] exp, got);
		cmp_count++;
		if (exp !== got) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask

	// One request cycle, then read data is settled after the edge.
	task automatic access(input logic w, input logic [7:0] a, d);
		cmd = '{rd: !w, wr: w, addr: a, wdata: d};
		step;
		cmd.rd = 1'b0;
		cmd.wr = 1'b0;
	endtask

	task automatic end_of_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// A hang is cut short well after the tests should end.
	initial begin
		#20000;
		num_errors++;
		end_of_test;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	// Reset, table rows, then masking and refused accesses.
	initial begin
		rst_n_in = 1'b0;
		cond = '0;
		cmd = '0;
		num_errors = 0;
		cmp_count = 0;
		repeat (4) step;
		rst_n_in = 1'b1;
		check("rdata_out", 8'h00, rdata);
		check("irq_n_out", 8'h01, {7'h00, irq_n});
		step;
		for (int a = 1; a < 3; a++) begin
			access(1'b0, 8'(a), 8'h00);
			check("event reset", 8'h00, rdata);
		end
		foreach (ROWS[i]) begin
			cond = ROWS[i][19:8];
			step;
			cond = '0;
			step;
			check("irq_n_out", {7'h00, ROWS[i][19:8] == 12'h000},
				{7'h00, irq_n});
			access(1'b0, ROWS[i][27:20], 8'h00);
			check("rdata_out", ROWS[i][7:0], rdata);
			access(1'b0, ROWS[i][27:20], 8'h00);
			check("reread", (i == 0) ? ID : 8'h00, rdata);
		end
		access(1'b1, pefi_pkg::ADDR_MASK_SYSTEM, 8'h3F);
		cond.thermal_warning = 1'b1;
		step;
		cond = '0;
		step;
		check("masked irq_n_out", 8'h01, {7'h00, irq_n});
		access(1'b0, pefi_pkg::ADDR_EVENT_SYSTEM, 8'h00);
		check("masked event", 8'h04, rdata);
		access(1'b1, pefi_pkg::ADDR_PART_IDENTITY, 8'hFF);
		access(1'b0, pefi_pkg::ADDR_PART_IDENTITY, 8'h00);
		check("identity after write", ID, rdata);
		access(1'b0, 8'h07, 8'h00);
		check("unmapped read", 8'h00, rdata);
		end_of_test;
	end
endmodule // pmic_event_flags_and_id_tb_top

`default_nettype wire
